//--- pfc_pwm_defines.svh
// offsets, field positions, reset values and prescaler counts of the pwm timer
`ifndef PFC_PWM_DEFINES_SVH
`define PFC_PWM_DEFINES_SVH
`define OFS_CTRL_A 12'h000
`define OFS_CTRL_B 12'h004
`define OFS_COUNTER 12'h008
`define OFS_CMP_A 12'h00C
`define OFS_CMP_B 12'h010
`define OFS_CAPTURE 12'h014
`define OFS_FLAGS 12'h018
`define OFS_PIN_DIR 12'h01C
`define FLD_ACT_A 7:6
`define FLD_ACT_B 5:4
`define FLD_MODE_LO 1:0
`define FLD_MODE_HI 4:3
`define FLD_PRESCALE 2:0
`define BIT_OVF 0
`define BIT_MATCH_A 1
`define BIT_MATCH_B 2
`define BIT_CAPT 5
`define RST_WORD 32'h0000_0000
`define RST_TOP 16'hFFFF
`define MODE_ICR_TOP 4'h8
`define MODE_CMPA_TOP 4'h9
`define MODE_CMPA_TOP_PC 4'hB
`define DIV_8 11'h008
`define DIV_64 11'h040
`define DIV_256 11'h100
`define DIV_1024 11'h400
`endif

//--- pfc_pwm_pkg.sv
// types shared by the pwm timer
package pfc_pwm_pkg;
    typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;
    typedef enum logic [1:0] {ACT_OFF = 2'h0, ACT_TOGGLE = 2'h1, ACT_NONINV = 2'h2,
        ACT_INV = 2'h3} action_t;
endpackage

//--- dual_slope_freq_correct_pwm.sv
// phase and frequency correct pwm timer with an ahb-lite register slave
// Function
// RQ1: modes 8 and 9 count 0x0000 up to TOP then back down, repeatedly.
// RQ2: non-inverting: clear output on up-count match, set on down-count match.
// RQ3: inverting: set output on up-count match, clear on down-count match.
// RQ4: TOP is capture value in mode 8, compare A in mode 9.
// RQ5: software keeps TOP at least 0x0003; maximum is full 16 bits.
// RQ6: counter holds TOP exactly one timer tick before decrementing.
// RQ7: channel match flag sets whenever counter equals its compare value.
// RQ8: at BOTTOM load buffered compares and set overflow flag same tick.
// RQ9: compare A flag or capture flag sets when counter reaches TOP.
// RQ10: software keeps TOP at or above every compare value.
// RQ11: compares change only at BOTTOM so both slopes stay equal.
// RQ12: action two gives non-inverted pwm, action three inverted pwm.
// RQ13: compare output reaches pin only when its direction bit is set.
// RQ14: tick is clock divided by 1, 8, 64, 256 or 1024.
// RQ15: compare BOTTOM gives constant low, TOP gives high; inverted opposite.
// RQ16: mode 9 with channel A action 1 toggles output A each match.
// RQ17: fully synchronous; the tick is a clock enable.
// RQ18: software should use compare A as TOP when changing frequency.
// RQ19: action zero disconnects; action one toggles A only in modes 9 or 11. Toggles only in mode 9; mode 11 enables pin A but never counts.
// RQ20: mode select low bits in control A, high bits in control B.
// RQ21: after reset counter counts up; flips at TOP and at BOTTOM.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pfc_pwm_defines.svh"
module dual_slope_freq_correct_pwm
    import pfc_pwm_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic compareOutputA,
    output logic compareOutputAEn,
    output logic compareOutputB,
    output logic compareOutputBEn
);
    logic [7:0] ctrlA_reg;
    logic [7:0] ctrlB_reg;
    logic [15:0] counter_reg;
    logic [15:0] cmpA_reg;
    logic [15:0] cmpB_reg;
    logic [15:0] cmpABuf_reg;
    logic [15:0] cmpBBuf_reg;
    logic [15:0] capture_reg;
    logic [5:0] flags_reg;
    logic [1:0] pinDir_reg;
    logic [10:0] presc_reg;
    dir_t dir_reg;
    dir_t stepDir;
    logic waveA_reg;
    logic waveB_reg;
    logic wrPend_reg;
    logic [11:0] wrAddr_reg;
    logic tick;
    logic [10:0] divide;
    logic [3:0] mode;
    logic pfcMode;
    logic [15:0] topValue;
    logic atTop;
    logic atBottom;
    logic matchA;
    logic matchB;
    action_t actA;
    action_t actB;
    logic busSel;
    logic [31:0] wData;

    // compare output reaction for one channel; returns new level
    function automatic logic waveNext(input logic cur, input logic hit, input dir_t d,
        input action_t a, input logic toggleOk);
        logic r;
        r = cur;
        if (hit)
        begin
            case (a)
                ACT_TOGGLE: r = toggleOk ? ~cur : cur;
                ACT_NONINV: r = (d == DIR_UP) ? 1'b0 : 1'b1;
                ACT_INV: r = (d == DIR_UP) ? 1'b1 : 1'b0;
                default: r = cur;
            endcase
        end
        return r;
    endfunction

    // mode split across two control registers
    assign mode = {ctrlB_reg[`FLD_MODE_HI], ctrlA_reg[`FLD_MODE_LO]}; // RQ20
    assign pfcMode = (mode == `MODE_ICR_TOP) || (mode == `MODE_CMPA_TOP); // RQ1
    assign topValue = (mode == `MODE_ICR_TOP) ? capture_reg : cmpA_reg; // RQ4
    assign atTop = pfcMode && (counter_reg == topValue);
    assign atBottom = pfcMode && (counter_reg == 16'h0000);
    assign matchA = pfcMode && (counter_reg == cmpA_reg);
    assign matchB = pfcMode && (counter_reg == cmpB_reg);
    assign actA = action_t'(ctrlA_reg[`FLD_ACT_A]);
    assign actB = action_t'(ctrlA_reg[`FLD_ACT_B]);

    // direction of the step leaving this value: bottom always leaves upward, top downward,
    // so a non-inverted compare at bottom gives a steady low and one at top a steady high, inverted the opposite
    always_comb
    begin
        if (atTop)
            stepDir = DIR_DOWN; // RQ15
        else if (atBottom)
            stepDir = DIR_UP; // RQ15
        else
            stepDir = dir_reg;
    end

    // prescaler select; zero select leaves the timer stopped
    always_comb
    begin
        case (ctrlB_reg[`FLD_PRESCALE])
            3'h1: divide = 11'h001;
            3'h2: divide = `DIV_8;
            3'h3: divide = `DIV_64;
            3'h4: divide = `DIV_256;
            3'h5: divide = `DIV_1024;
            default: divide = 11'h000;
        endcase
    end

    // tick is an enable on core_clk, never a clock of its own
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            presc_reg <= 11'h000;
        else if (divide == 11'h000 || presc_reg >= divide - 11'h001)
            presc_reg <= 11'h000; // RQ17
        else
            presc_reg <= presc_reg + 11'h001;
    end
    assign tick = (divide != 11'h000) && (presc_reg >= divide - 11'h001); // RQ14

    // bus address phase is captured; write data lands one cycle later
    assign busSel = hsel && hready && htrans[1];
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 12'h000;
        end
        else
        begin
            wrPend_reg <= busSel && hwrite;
            if (busSel)
                wrAddr_reg <= haddr;
        end
    end
    assign wData = hwdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // read data registered from the address phase
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            hrdata <= `RST_WORD;
        else if (busSel && !hwrite)
        begin
            case (haddr)
                `OFS_CTRL_A: hrdata <= {24'h0, ctrlA_reg};
                `OFS_CTRL_B: hrdata <= {24'h0, ctrlB_reg};
                `OFS_COUNTER: hrdata <= {16'h0, counter_reg};
                `OFS_CMP_A: hrdata <= {16'h0, cmpABuf_reg};
                `OFS_CMP_B: hrdata <= {16'h0, cmpBBuf_reg};
                `OFS_CAPTURE: hrdata <= {16'h0, capture_reg};
                `OFS_FLAGS: hrdata <= {26'h0, flags_reg};
                `OFS_PIN_DIR: hrdata <= {30'h0, pinDir_reg};
                default: hrdata <= `RST_WORD;
            endcase
        end
    end

    // control, capture-value and direction registers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrlA_reg <= 8'h00;
            ctrlB_reg <= 8'h00;
            capture_reg <= `RST_TOP;
            pinDir_reg <= 2'b00;
        end
        else if (wrPend_reg)
        begin
            case (wrAddr_reg)
                `OFS_CTRL_A: ctrlA_reg <= wData[7:0] & 8'hF3;
                `OFS_CTRL_B: ctrlB_reg <= wData[7:0] & 8'h1F;
                `OFS_CAPTURE: capture_reg <= wData[15:0];
                `OFS_PIN_DIR: pinDir_reg <= wData[1:0];
                default: ;
            endcase
        end
    end

    // software writes only reach the buffers; actives load at BOTTOM in modes 8 and 9, every cycle otherwise
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmpABuf_reg <= `RST_TOP;
            cmpBBuf_reg <= 16'h0000;
        end
        else if (wrPend_reg && wrAddr_reg == `OFS_CMP_A)
            cmpABuf_reg <= wData[15:0];
        else if (wrPend_reg && wrAddr_reg == `OFS_CMP_B)
            cmpBBuf_reg <= wData[15:0];
    end

    // double buffer keeps both slopes of a period the same length
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmpA_reg <= `RST_TOP;
            cmpB_reg <= 16'h0000;
        end
        else if (!pfcMode || (tick && atBottom))
        begin
            cmpA_reg <= cmpABuf_reg; // RQ8 RQ11
            cmpB_reg <= cmpBBuf_reg;
        end
    end

    // up/down counter; top lasts one tick since direction flips there
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            counter_reg <= 16'h0000;
            dir_reg <= DIR_UP; // RQ21
        end
        else if (wrPend_reg && wrAddr_reg == `OFS_COUNTER)
            counter_reg <= wData[15:0];
        else if (tick && pfcMode)
        begin
            case (dir_reg)
                DIR_UP:
                begin
                    if (atTop)
                    begin
                        dir_reg <= DIR_DOWN; // RQ4 RQ6
                        counter_reg <= counter_reg - 16'h0001;
                    end
                    else
                        counter_reg <= counter_reg + 16'h0001; // RQ1
                end
                DIR_DOWN:
                begin
                    if (atBottom)
                    begin
                        dir_reg <= DIR_UP; // RQ21
                        counter_reg <= counter_reg + 16'h0001;
                    end
                    else
                        counter_reg <= counter_reg - 16'h0001;
                end
                default: dir_reg <= DIR_UP;
            endcase
        end
    end

    // flags: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            flags_reg <= 6'h00;
        else
        begin
            for (int i = 0; i < 6; i++)
            begin
                if (wrPend_reg && wrAddr_reg == `OFS_FLAGS && wData[i])
                    flags_reg[i] <= 1'b0;
            end
            if (tick && atBottom)
                flags_reg[`BIT_OVF] <= 1'b1; // RQ8
            if (tick && (matchA || (atTop && mode == `MODE_CMPA_TOP)))
                flags_reg[`BIT_MATCH_A] <= 1'b1; // RQ7 RQ9
            if (tick && matchB)
                flags_reg[`BIT_MATCH_B] <= 1'b1; // RQ7
            if (tick && atTop && mode == `MODE_ICR_TOP)
                flags_reg[`BIT_CAPT] <= 1'b1; // RQ9
        end
    end

    // waveform levels; match at BOTTOM or TOP yields constant low or high
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            waveA_reg <= 1'b0;
            waveB_reg <= 1'b0;
        end
        else if (tick)
        begin
            waveA_reg <= waveNext(waveA_reg, matchA, stepDir, actA,
                mode == `MODE_CMPA_TOP); // RQ2 RQ3 RQ12 RQ15 RQ16 RQ19
            waveB_reg <= waveNext(waveB_reg, matchB, stepDir, actB, 1'b0); // RQ2 RQ3
        end
    end

    // pin drive needs a connected action and the direction bit
    always_comb
    begin
        compareOutputA = waveA_reg;
        compareOutputB = waveB_reg;
        compareOutputAEn = pinDir_reg[0] && (actA == ACT_NONINV || actA == ACT_INV ||
            (actA == ACT_TOGGLE && (mode == `MODE_CMPA_TOP || mode == `MODE_CMPA_TOP_PC)));
        compareOutputBEn = pinDir_reg[1] && (actB == ACT_NONINV || actB == ACT_INV); // RQ13 RQ19
    end

    // overflow flag is always set the cycle after a tick at bottom
    bottom_ovf_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ8
        (tick && atBottom) |=> flags_reg[`BIT_OVF])
        else $error("overflow flag missed at bottom");
    top_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ6
        (tick && atTop && dir_reg == DIR_UP && !wrPend_reg) |=> dir_reg == DIR_DOWN)
        else $error("direction did not flip at top");
    buffer_load_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ11
        (pfcMode && $changed(cmpA_reg)) |-> $past(tick && atBottom))
        else $error("compare changed away from bottom");
    noninv_up_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ2
        (tick && matchA && actA == ACT_NONINV && stepDir == DIR_UP) |=> !waveA_reg)
        else $error("output not cleared on up match");
    inv_down_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ3
        (tick && matchB && actB == ACT_INV && stepDir == DIR_DOWN) |=> !waveB_reg)
        else $error("inverted output not cleared on down match");
    pin_gate_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ13
        !pinDir_reg[0] |-> !compareOutputAEn)
        else $error("pin driven without direction bit");
    top_flag_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ9
        (tick && atTop && mode == `MODE_ICR_TOP) |=> flags_reg[`BIT_CAPT])
        else $error("capture flag missed at top");
    bottom_turn_a: assert property (@(posedge core_clk) disable iff (!nrst) // RQ21
        (tick && atBottom && !wrPend_reg) |=> dir_reg == DIR_UP)
        else $error("direction not upward after bottom");
endmodule
`default_nettype wire

//--- dual_slope_freq_correct_pwm_bench.sv
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/100ps
`default_nettype none
`include "pfc_pwm_defines.svh"
module dual_slope_freq_correct_pwm_bench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, compareOutputA, compareOutputAEn, compareOutputB, compareOutputBEn;
    logic readPhase = 1'b0;
    logic [31:0] expQ[$];
    int checks = 0;
    int badCount = 0;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    // single slave, so its ready is the bus ready
    dual_slope_freq_correct_pwm dual_slope_freq_correct_pwm_inst (
        .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .compareOutputA(compareOutputA), .compareOutputAEn(compareOutputAEn),
        .compareOutputB(compareOutputB), .compareOutputBEn(compareOutputBEn));

    task automatic stopTest;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("MISMATCH t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic checkWave(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("MISMATCH t=%0t wave got %h exp %h", $time, got, exp);
        end
    endtask

    // enables come straight from registers, so let the write edge settle first
    task automatic checkEn(input logic expA, input logic expB);
        #1;
        checkWave({14'h0, compareOutputAEn, compareOutputBEn}, {14'h0, expA, expB});
    endtask

    // one single transfer; a read notes its expected word for the monitor
    task automatic busXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        if (!wr)
            expQ.push_back(d);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic cfg(input logic [31:0] top, input logic [31:0] ca, input logic [31:0] cb,
        input logic [31:0] ctA, input logic [31:0] ctB);
        busXfer(1'b1, `OFS_CAPTURE, top);
        busXfer(1'b1, `OFS_CMP_A, ca);
        busXfer(1'b1, `OFS_CMP_B, cb);
        busXfer(1'b1, `OFS_CTRL_A, ctA);
        busXfer(1'b1, `OFS_CTRL_B, ctB);
    endtask

    // counts high cycles of A and B and rising edges of A over n whole cycles
    task automatic sample(input int n, output logic [15:0] hiA, output logic [15:0] hiB,
        output logic [15:0] upA);
        logic prevA;
        hiA = 16'h0;
        hiB = 16'h0;
        upA = 16'h0;
        #1;
        prevA = compareOutputA;
        repeat (n)
        begin
            @(posedge core_clk);
            #1;
            hiA += {15'h0, compareOutputA};
            hiB += {15'h0, compareOutputB};
            upA += {15'h0, compareOutputA & ~prevA};
            prevA = compareOutputA;
        end
    endtask

    // read data stands in the data phase, so remember each read address phase
    always @(posedge core_clk)
    begin
        if (readPhase && hreadyout === 1'b1)
        begin
            checkWord(hrdata, expQ.pop_front());
            checkWord({31'h0, hresp}, 32'h0);
        end
        if (hreadyout === 1'b1)
            readPhase <= hsel && htrans[1] && !hwrite;
    end

    // a hang ends the run through the same closing task
    initial
    begin
        repeat (40000) @(posedge core_clk);
        badCount++;
        stopTest();
    end

    initial
    begin
        logic [15:0] hiA, hiB, upA;
        int c;
        logic [11:0] ra [9] = '{`OFS_CTRL_A, `OFS_CTRL_B, `OFS_COUNTER, `OFS_CMP_A, `OFS_CMP_B,
            `OFS_CAPTURE, `OFS_FLAGS, `OFS_PIN_DIR, 12'h100};
        logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
        int divs [5] = '{1, `DIV_8, `DIV_64, `DIV_256, `DIV_1024};
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        void'($urandom(32'h0291f335));
        // reset values, unmapped address last
        for (int i = 0; i < 9; i++)
            busXfer(1'b0, ra[i], rv[i]);
        checkEn(1'b0, 1'b0);
        busXfer(1'b1, `OFS_PIN_DIR, 32'h3);
        // mode 8, top 7: a non-inverted, b inverted; extremes first, then random
        for (int i = 0; i < 4; i++)
        begin
            c = (i == 0) ? 0 : (i == 1) ? 7 : $urandom_range(0, 7);
            cfg(32'h7, 32'(c), 32'(c), 32'hB0, 32'h11);
            repeat (30) @(posedge core_clk);
            sample(14, hiA, hiB, upA);
            checkWave(hiA, 16'(2 * c));
            checkWave(hiB, 16'(14 - 2 * c));
        end
        checkEn(1'b1, 1'b1);
        busXfer(1'b0, `OFS_CTRL_A, 32'hB0);
        busXfer(1'b0, `OFS_CTRL_B, 32'h11);
        busXfer(1'b0, `OFS_FLAGS, 32'h27);
        busXfer(1'b1, `OFS_PIN_DIR, 32'h1);
        checkEn(1'b1, 1'b0);
        busXfer(1'b1, `OFS_CTRL_A, 32'h40);
        checkEn(1'b0, 1'b0);
        busXfer(1'b1, `OFS_PIN_DIR, 32'h3);
        // mode 9, top 5 from compare a: a toggles, b non-inverted at 2
        // new top must be active and the counter below it before mode 9 runs
        busXfer(1'b1, `OFS_CMP_A, 32'h5);
        repeat (16) @(posedge core_clk);
        busXfer(1'b1, `OFS_CTRL_B, 32'h10);
        busXfer(1'b1, `OFS_COUNTER, 32'h0);
        cfg(32'h7, 32'h5, 32'h2, 32'h61, 32'h11);
        repeat (40) @(posedge core_clk);
        sample(20, hiA, hiB, upA);
        checkWave(hiA, 16'd10);
        checkWave(upA, 16'd1);
        checkWave(hiB, 16'd8);
        checkEn(1'b1, 1'b1);
        // stop the tick so flags stay cleared
        busXfer(1'b1, `OFS_CTRL_B, 32'h10);
        busXfer(1'b1, `OFS_FLAGS, 32'h27);
        busXfer(1'b0, `OFS_FLAGS, 32'h0);
        // counter may sit above the coming top of 3, so restart it from bottom
        busXfer(1'b1, `OFS_COUNTER, 32'h0);
        // minimum top of 3 at every prescaler: period is 6 ticks
        for (int k = 1; k < 6; k++)
        begin
            cfg(32'h3, 32'h1, 32'h1, 32'hA0, 32'h10 | 32'(k));
            repeat (7 * divs[k - 1]) @(posedge core_clk);
            sample(12 * divs[k - 1], hiA, hiB, upA);
            checkWave(upA, 16'd2);
            checkWave(hiA, 16'(4 * divs[k - 1]));
        end
        repeat (3) @(posedge core_clk);
        stopTest();
    end
endmodule
`default_nettype wire
